// File: core/eds_regs.svh
// Offsets, field positions, reset values and constants of the DMA status/control register
`ifndef EDS_REGS_SVH
`define EDS_REGS_SVH
`define EDS_OFF_STATUS_CONTROL 12'h000
`define EDS_TX_DEPTH_HI        31
`define EDS_TX_DEPTH_LO        28
`define EDS_TX_WIDTH_HI        27
`define EDS_TX_WIDTH_LO        26
`define EDS_TX_CHAN_HI         25
`define EDS_TX_CHAN_LO         24
`define EDS_RX_DEPTH_HI        23
`define EDS_RX_DEPTH_LO        20
`define EDS_RX_WIDTH_HI        19
`define EDS_RX_WIDTH_LO        18
`define EDS_RX_CHAN_HI         17
`define EDS_RX_CHAN_LO         16
`define EDS_REV_HI             15
`define EDS_REV_LO             8
`define EDS_TX_BURST_HI        7
`define EDS_TX_BURST_LO        6
`define EDS_RX_BURST_HI        5
`define EDS_RX_BURST_LO        4
`define EDS_LOOPBACK_BIT       1
`define EDS_SOFT_RESET_BIT     0
`define EDS_RST_BURST          2'h0
`define EDS_RST_LOOPBACK       1'h0
`define EDS_RST_SOFT_RESET     1'h1
`define EDS_DEF_DEPTH          4'h4
`define EDS_DEF_WIDTH          2'h2
`define EDS_DEF_CHAN           2'h2
`define EDS_DEF_REV            8'h01
`endif

// File: core/eds_pkg.sv
// Types shared by the DMA status/control block
package eds_pkg;
  typedef enum logic [1:0] {
    EDS_BURST_INCR16 = 2'b00,
    EDS_BURST_INCR8  = 2'b01,
    EDS_BURST_INCR4  = 2'b10,
    EDS_BURST_SINGLE = 2'b11
  } eds_burst_t;

  typedef enum logic [1:0] {
    EDS_RUN       = 2'b00,
    EDS_DRAINING  = 2'b01,
    EDS_HELD      = 2'b10
  } eds_rst_state_t;
endpackage : eds_pkg

// File: core/eds_burst_limit.sv
// Burst length limiter for one DMA direction
module eds_burst_limit
  import eds_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic [1:0] burst_code,
  input  wire logic       desc_fetch,
  output logic      [4:0] max_beats_r
);
  typedef struct packed {
    logic [4:0] beats;
  } eds_bl_state_t;

  eds_bl_state_t st_r;
  eds_bl_state_t st_nxt;

  function automatic logic [4:0] eds_beats(input logic [1:0] code);
    case (code)
      EDS_BURST_INCR16: eds_beats = 5'h10;
      EDS_BURST_INCR8:  eds_beats = 5'h08;
      EDS_BURST_INCR4:  eds_beats = 5'h04;
      default:          eds_beats = 5'h01;
    endcase
  endfunction : eds_beats

  always_comb begin
    st_nxt = st_r;
    // Descriptor fetches keep their own fixed length
    if (desc_fetch) begin
      st_nxt.beats = 5'h10;
    end else begin
      st_nxt.beats = eds_beats(burst_code);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // Matches the burst field reset code 00, so no zero-beat window
      st_r.beats <= 5'h10;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign max_beats_r = st_r.beats;

  chk_fetch_unlimited: assert property (@(posedge clk_sys) disable iff (!arst_n)
    desc_fetch |=> max_beats_r == 5'h10) else $error("fetch limited");
  chk_single_beat: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!desc_fetch && burst_code == 2'b11) |=> max_beats_r == 5'h01)
    else $error("single not one beat");
endmodule : eds_burst_limit

// File: core/eds_status_control.sv
// DMA status/control register with APB slave, soft reset and burst limits
`include "eds_regs.svh"

module eds_status_control
  import eds_pkg::*;
#(
  parameter logic [3:0] TX_DEPTH_CODE = `EDS_DEF_DEPTH,
  parameter logic [3:0] RX_DEPTH_CODE = `EDS_DEF_DEPTH,
  parameter logic [1:0] TX_WIDTH_CODE = `EDS_DEF_WIDTH,
  parameter logic [1:0] RX_WIDTH_CODE = `EDS_DEF_WIDTH,
  parameter logic [1:0] TX_CHAN_CODE  = `EDS_DEF_CHAN,
  parameter logic [1:0] RX_CHAN_CODE  = `EDS_DEF_CHAN,
  // Revision value is arbitrary
  parameter logic [7:0] REVISION_CODE = `EDS_DEF_REV
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        ahb_queue_busy,
  input  wire logic        tx_desc_fetch,
  input  wire logic        rx_desc_fetch,
  output logic             mac_dma_rst_r,
  output logic             loopback_select,
  output logic      [4:0]  tx_max_beats,
  output logic      [4:0]  rx_max_beats
);
  typedef struct packed {
    logic [31:0]    rdata;
    logic           ready;
    logic           slverr;
    logic [1:0]     tx_burst;
    logic [1:0]     rx_burst;
    logic           loopback;
    logic           soft_reset_hold;
    eds_rst_state_t rst_state;
    logic           core_rst;
  } eds_state_t;

  eds_state_t st_r;
  eds_state_t st_nxt;

  logic access;
  logic hit;

  function automatic logic [31:0] eds_read_word(input eds_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`EDS_TX_DEPTH_HI:`EDS_TX_DEPTH_LO] = TX_DEPTH_CODE;
    w[`EDS_TX_WIDTH_HI:`EDS_TX_WIDTH_LO] = TX_WIDTH_CODE;
    w[`EDS_TX_CHAN_HI:`EDS_TX_CHAN_LO]   = TX_CHAN_CODE;
    w[`EDS_RX_DEPTH_HI:`EDS_RX_DEPTH_LO] = RX_DEPTH_CODE;
    w[`EDS_RX_WIDTH_HI:`EDS_RX_WIDTH_LO] = RX_WIDTH_CODE;
    w[`EDS_RX_CHAN_HI:`EDS_RX_CHAN_LO]   = RX_CHAN_CODE;
    w[`EDS_REV_HI:`EDS_REV_LO]           = REVISION_CODE;
    w[`EDS_TX_BURST_HI:`EDS_TX_BURST_LO] = s.tx_burst;
    w[`EDS_RX_BURST_HI:`EDS_RX_BURST_LO] = s.rx_burst;
    w[`EDS_LOOPBACK_BIT]                 = s.loopback;
    w[`EDS_SOFT_RESET_BIT]               = s.soft_reset_hold;
    return w;
  endfunction : eds_read_word

  assign access = psel && penable && !st_r.ready;
  assign hit    = (paddr == `EDS_OFF_STATUS_CONTROL);

  always_comb begin
    st_nxt        = st_r;
    st_nxt.ready  = 1'b0;
    st_nxt.slverr = 1'b0;
    // One wait state: answer lands in the cycle after the first access cycle
    if (access) begin
      st_nxt.ready  = 1'b1;
      st_nxt.slverr = !hit;
      st_nxt.rdata  = 32'h0000_0000;
      if (hit && !pwrite) begin
        st_nxt.rdata = eds_read_word(st_r);
      end
      // Only writable fields take data, per byte lane
      if (hit && pwrite && pstrb[0]) begin
        st_nxt.tx_burst = pwdata[`EDS_TX_BURST_HI:`EDS_TX_BURST_LO];
        st_nxt.rx_burst = pwdata[`EDS_RX_BURST_HI:`EDS_RX_BURST_LO];
        st_nxt.loopback = pwdata[`EDS_LOOPBACK_BIT];
        st_nxt.soft_reset_hold = pwdata[`EDS_SOFT_RESET_BIT];
      end
    end
    // Except at arst_n and from an illegal state, reset asserts only once the master queue is
    // empty, so no bus transfer is cut in half; release is immediate.
    case (st_r.rst_state)
      EDS_RUN: begin
        if (st_r.soft_reset_hold) begin
          st_nxt.rst_state = EDS_DRAINING;
        end
      end
      EDS_DRAINING: begin
        if (!st_r.soft_reset_hold) begin
          st_nxt.rst_state = EDS_RUN;
        end else if (!ahb_queue_busy) begin
          st_nxt.rst_state = EDS_HELD;
          st_nxt.core_rst  = 1'b1;
        end
      end
      EDS_HELD: begin
        if (!st_r.soft_reset_hold) begin
          st_nxt.rst_state = EDS_RUN;
          st_nxt.core_rst  = 1'b0;
        end
      end
      default: begin
        st_nxt.rst_state = EDS_HELD;
        st_nxt.core_rst  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r.rdata           <= 32'h0000_0000;
      st_r.ready           <= 1'b0;
      st_r.slverr          <= 1'b0;
      st_r.tx_burst        <= `EDS_RST_BURST;
      st_r.rx_burst        <= `EDS_RST_BURST;
      st_r.loopback        <= `EDS_RST_LOOPBACK;
      st_r.soft_reset_hold <= `EDS_RST_SOFT_RESET;
      st_r.rst_state       <= EDS_HELD;
      st_r.core_rst        <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready          = st_r.ready;
  assign prdata          = st_r.rdata;
  assign pslverr         = st_r.slverr;
  assign mac_dma_rst_r   = st_r.core_rst;
  assign loopback_select = st_r.loopback;

  eds_burst_limit u_tx_limit (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .burst_code  (st_r.tx_burst),
    .desc_fetch  (tx_desc_fetch),
    .max_beats_r (tx_max_beats)
  );

  eds_burst_limit u_rx_limit (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .burst_code  (st_r.rx_burst),
    .desc_fetch  (rx_desc_fetch),
    .max_beats_r (rx_max_beats)
  );

  default clocking eds_cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_const_fields: assert property (
    pready && !pwrite && !pslverr |->
      prdata[31:8] == {TX_DEPTH_CODE, TX_WIDTH_CODE, TX_CHAN_CODE,
                       RX_DEPTH_CODE, RX_WIDTH_CODE, RX_CHAN_CODE,
                       REVISION_CODE})
    else $error("parameter fields wrong");
  chk_reserved_zero: assert property (
    pready |-> prdata[3:2] == 2'b00)
    else $error("reserved bits not zero");
  chk_tx_burst_wr: assert property (
    psel && penable && !pready && pwrite && hit && pstrb[0]
      |=> st_r.tx_burst == $past(pwdata[7:6]))
    else $error("tx burst not written");
  chk_rx_burst_wr: assert property (
    psel && penable && !pready && pwrite && hit && pstrb[0]
      |=> st_r.rx_burst == $past(pwdata[5:4]))
    else $error("rx burst not written");
  chk_loop_write: assert property (
    psel && penable && !pready && pwrite && hit && pstrb[0]
      |=> loopback_select == $past(pwdata[1]))
    else $error("loopback not written");
  chk_rst_waits_bus: assert property (
    $rose(mac_dma_rst_r) |-> !$past(ahb_queue_busy))
    else $error("reset during bus transfer");
  chk_rst_release: assert property (
    mac_dma_rst_r && !st_r.soft_reset_hold |=> !mac_dma_rst_r)
    else $error("reset not released");
  chk_rst_engage: assert property (
    !mac_dma_rst_r && st_r.soft_reset_hold && !ahb_queue_busy
      |=> ##1 mac_dma_rst_r || !st_r.soft_reset_hold)
    else $error("reset not engaged");
  chk_ro_ignored: assert property (
    pready |=> ##0 1'b1 ##0 (eds_read_word(st_r) & 32'hFFFF_FF0C) ==
      {TX_DEPTH_CODE, TX_WIDTH_CODE, TX_CHAN_CODE, RX_DEPTH_CODE,
       RX_WIDTH_CODE, RX_CHAN_CODE, REVISION_CODE, 8'h00})
    else $error("read-only field changed");
  chk_one_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("no answer after one wait");

  cov_release: cover property ($fell(mac_dma_rst_r));
  cov_drain: cover property (st_r.rst_state == EDS_DRAINING ##1
                             st_r.rst_state == EDS_HELD);
  cov_bad_addr: cover property (pready && pslverr);
  cov_loop_on: cover property ($rose(loopback_select));
endmodule : eds_status_control

// File: bench/ethernet_dma_status_control_bench.sv
// Self-checking bench for the DMA status/control register
`include "eds_regs.svh"
module ethernet_dma_status_control_bench
  import eds_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] RO_HI = {`EDS_DEF_DEPTH, `EDS_DEF_WIDTH,
    `EDS_DEF_CHAN, `EDS_DEF_DEPTH, `EDS_DEF_WIDTH, `EDS_DEF_CHAN,
    `EDS_DEF_REV};
  localparam logic [4:0] BEATS [4] = '{5'h10, 5'h08, 5'h04, 5'h01};
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic        ahb_queue_busy = 1'b0;
  logic        tx_desc_fetch = 1'b0;
  logic        rx_desc_fetch = 1'b0;
  logic        pready, pslverr, mac_dma_rst_r, loopback_select, er;
  logic [31:0] prdata, rd;
  logic [4:0]  tx_max_beats, rx_max_beats;
  int          n_mismatch = 0;
  int          compares = 0;

  always #20 clk_sys = ~clk_sys;

  eds_status_control dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ahb_queue_busy(ahb_queue_busy), .tx_desc_fetch(tx_desc_fetch),
    .rx_desc_fetch(rx_desc_fetch), .mac_dma_rst_r(mac_dma_rst_r),
    .loopback_select(loopback_select), .tx_max_beats(tx_max_beats),
    .rx_max_beats(rx_max_beats));

  task wrap_up;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      n_mismatch++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_rst(input logic v);
    int n;
    for (n = 0; n < 8; n++) begin
      @(posedge clk_sys);
      if (mac_dma_rst_r === v) break;
    end
    chk(32'(mac_dma_rst_r), 32'(v));
    if (n == 8) wrap_up();
  endtask : wait_rst

  task t_reset;
    chk(32'(mac_dma_rst_r), 32'h1);
    chk(32'(tx_max_beats), 32'h10);
    // A write of 0 clears bit 0 while held, so the release is seen at the port
    apb(1'b1, 12'h000, 32'h0, 4'hF);
    wait_rst(1'b0);
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk(rd, {RO_HI, 8'h00});
    chk(32'(er), 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task t_fields;
    apb(1'b1, 12'h000, 32'hFFFFFFFE, 4'hF);
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk(rd, {RO_HI, 8'hF2});
    chk(32'(loopback_select), 32'h1);
    apb(1'b1, 12'h000, 32'h0, 4'hF);
    @(posedge clk_sys);
    chk(32'(loopback_select), 32'h0);
    $display("t_fields done");
  endtask : t_fields

  task t_bursts;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h000, {24'h0, c[1:0], 2'(3 - c), 4'h0}, 4'hF);
      repeat (2) @(posedge clk_sys);
      chk(32'(tx_max_beats), 32'(BEATS[c]));
      chk(32'(rx_max_beats), 32'(BEATS[3 - c]));
    end
    $display("t_bursts done");
  endtask : t_bursts

  task t_fetch;
    apb(1'b1, 12'h000, 32'h000000F0, 4'hF);
    tx_desc_fetch <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(32'(tx_max_beats), 32'h10);
    chk(32'(rx_max_beats), 32'h01);
    tx_desc_fetch <= 1'b0;
    rx_desc_fetch <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(32'(rx_max_beats), 32'h10);
    chk(32'(tx_max_beats), 32'h01);
    rx_desc_fetch <= 1'b0;
    $display("t_fetch done");
  endtask : t_fetch

  task t_refuse;
    apb(1'b1, 12'h000, 32'h00000002, 4'h0);
    apb(1'b1, 12'h004, 32'h00000002, 4'hF);
    chk(32'(er), 32'h1);
    apb(1'b0, 12'h004, 32'h0, 4'hF);
    chk(32'(er), 32'h1);
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk(rd, {RO_HI, 8'hF0});
    $display("t_refuse done");
  endtask : t_refuse

  task t_drain;
    ahb_queue_busy <= 1'b1;
    apb(1'b1, 12'h000, 32'h00000001, 4'hF);
    repeat (4) @(posedge clk_sys);
    chk(32'(mac_dma_rst_r), 32'h0);
    ahb_queue_busy <= 1'b0;
    wait_rst(1'b1);
    apb(1'b1, 12'h000, 32'h0, 4'hF);
    wait_rst(1'b0);
    $display("t_drain done");
  endtask : t_drain

  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_fields();
    t_bursts();
    t_fetch();
    t_refuse();
    t_drain();
    wrap_up();
  end
endmodule : ethernet_dma_status_control_bench
